// ==== pkg/dcs_defines.svh ====
// Constants for the drive command and state word logic.
// Assumes inclusion by bare name from the design files; the package does not include it.
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

// ======================================================================
// Object indices and reset values
`define DCS_CMD_WORD_IDX     16'h6040
`define DCS_STATE_WORD_IDX   16'h6041
`define DCS_STATE_WORD_RST   16'h0000

// ======================================================================
// Command word bit positions
`define DCS_CMD_SWITCH_ON    0
`define DCS_CMD_EN_VOLT      1
`define DCS_CMD_QSTOP_N      2
`define DCS_CMD_EN_OP        3
`define DCS_CMD_START        4
`define DCS_CMD_IMMEDIATE    5
`define DCS_CMD_RELATIVE     6
`define DCS_CMD_FAULT_RESET  7
`define DCS_CMD_HALT         8
`define DCS_CMD_CHANGE_SET   9
`define DCS_CMD_TLIM_POS     11
`define DCS_CMD_TLIM_NEG     12

// ======================================================================
// State word bit positions
`define DCS_ST_MAIN_POWER    4
`define DCS_ST_WARNING       7
`define DCS_ST_ACTIVE_MODE   8
`define DCS_ST_REMOTE        9
`define DCS_ST_INT_LIMIT     11
`define DCS_ST_TORQUE_LIMIT  14
`define DCS_ST_SAFETY        15

// ======================================================================
// Interpolation speed ceiling in inc/ms and microseconds per millisecond
`define DCS_IP_SPEED_LIMIT   80'h400000
`define DCS_US_PER_MS        80'h3E8

`endif

// ==== pkg/dcs_pkg.sv ====
// Types for the drive command and state word logic.
// Assumes nothing beyond the constant header.
package dcs_pkg;

  // Operating modes as selected by the drive firmware.
  typedef enum logic [2:0] {
    DCS_MODE_PP  = 3'h0,
    DCS_MODE_HM  = 3'h1,
    DCS_MODE_IP  = 3'h2,
    DCS_MODE_CSP = 3'h3,
    DCS_MODE_CSV = 3'h4,
    DCS_MODE_CST = 3'h5,
    DCS_MODE_PV  = 3'h6,
    DCS_MODE_PT  = 3'h7
  } dcs_mode_type;

  // Drive state machine, one-hot.
  typedef enum logic [7:0] {
    DCS_NOT_READY  = 8'h01,
    DCS_SW_ON_DIS  = 8'h02,
    DCS_READY      = 8'h04,
    DCS_SWITCHED   = 8'h08,
    DCS_OP_ENABLED = 8'h10,
    DCS_QSTOP      = 8'h20,
    DCS_FAULT_REAC = 8'h40,
    DCS_FAULT      = 8'h80
  } dcs_state_type;

endpackage

// ==== hdl/dcs_ip_speed_check.sv ====
// Interpolation speed check for a new target position.
// Assumes inputs are stable on the cycle they are sampled; result is registered.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defines.svh"

module dcs_ip_speed_check #(
  parameter int POS_W = 32,
  parameter int RAT_W = 32,
  parameter int PER_W = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [POS_W-1:0] new_target_i,
  input  wire logic [POS_W-1:0] demand_pos_i,
  input  wire logic [RAT_W-1:0] ratio_num_i,
  input  wire logic [RAT_W-1:0] ratio_den_i,
  input  wire logic [PER_W-1:0] period_us_i,
  output logic                  too_fast_o
);

  // ====================================================================
  // Cross-multiplied compare
  // Division is avoided: step*num*1000 >= limit*den*period_us is the same
  // test as the step rate reaching the ceiling, and exact for all inputs.
  logic [POS_W-1:0] diff;
  logic [POS_W-1:0] step_abs;
  logic [79:0]      lhs;
  logic [79:0]      rhs;
  logic             too_fast_q;

  assign diff     = new_target_i - demand_pos_i;
  assign step_abs = diff[POS_W-1] ? (~diff + 1'b1) : diff;
  assign lhs      = 80'(step_abs) * 80'(ratio_num_i) * `DCS_US_PER_MS;
  assign rhs      = `DCS_IP_SPEED_LIMIT * 80'(ratio_den_i) * 80'(period_us_i);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      too_fast_q <= 1'b0;
    end else if (ce_i) begin
      too_fast_q <= (lhs >= rhs);
    end
  end

  assign too_fast_o = too_fast_q;

endmodule
`default_nettype wire

// ==== hdl/dcs_drive_word.sv ====
// Command word decode and state word assembly for the motion drive.
// Assumes the fieldbus layer presents the cyclic command word and target on
// core_clk_i, and the motion core returns its status levels on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defines.svh"

module dcs_drive_word #(
  parameter int POS_W = 32,
  parameter int RAT_W = 32,
  parameter int PER_W = 16
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire dcs_pkg::dcs_mode_type mode_i,
  input  wire logic [15:0]           cmd_word_i,
  input  wire logic                  cmd_wr_i,
  input  wire logic [POS_W-1:0]      target_in_i,
  input  wire logic                  target_wr_i,
  input  wire logic [POS_W-1:0]      demand_pos_i,
  input  wire logic [RAT_W-1:0]      ratio_num_i,
  input  wire logic [RAT_W-1:0]      ratio_den_i,
  input  wire logic [PER_W-1:0]      period_us_i,
  input  wire logic                  target_reached_i,
  input  wire logic                  stop_done_i,
  input  wire logic                  fault_i,
  input  wire logic                  main_power_i,
  input  wire logic                  warning_i,
  input  wire logic                  active_func_i,
  input  wire logic                  safety_i,
  input  wire logic                  sw_limit_clip_i,
  input  wire logic                  reverse_overtravel_input,
  input  wire logic                  forward_overtravel_input,
  output logic [15:0]                state_word_o,
  output logic [POS_W-1:0]           target_pos_o,
  output logic                       setpoint_start_o,
  output logic                       target_ignored_o,
  output logic                       halt_o,
  output logic                       homing_run_o,
  output logic                       interp_en_o,
  output logic                       power_stage_on_o
);
  import dcs_pkg::*;

  // ====================================================================
  // Overtravel pin synchronisers
  // The first stage feeds only the second; a change is taken once the
  // second and third stages agree, which also rejects one-cycle glitches.
  logic [2:0] rot_sync_q;
  logic [2:0] fot_sync_q;
  logic       rot_q;
  logic       fot_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rot_sync_q <= 3'h0;
      fot_sync_q <= 3'h0;
      rot_q      <= 1'b0;
      fot_q      <= 1'b0;
    end else if (ce_i) begin
      rot_sync_q <= {rot_sync_q[1:0], reverse_overtravel_input};
      fot_sync_q <= {fot_sync_q[1:0], forward_overtravel_input};
      if (rot_sync_q[1] == rot_sync_q[2]) begin
        rot_q <= rot_sync_q[2];
      end
      if (fot_sync_q[1] == fot_sync_q[2]) begin
        fot_q <= fot_sync_q[2];
      end
    end
  end

  // ====================================================================
  // Command word capture and decode
  logic [15:0] cmd_q;
  logic        start_prev_q;
  logic        fault_rst_prev_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_q            <= 16'h0000;
      start_prev_q     <= 1'b0;
      fault_rst_prev_q <= 1'b0;
    end else if (ce_i) begin
      if (cmd_wr_i) begin
        cmd_q <= cmd_word_i;
      end
      start_prev_q     <= cmd_q[`DCS_CMD_START];
      fault_rst_prev_q <= cmd_q[`DCS_CMD_FAULT_RESET];
    end
  end

  wire       is_pp      = (mode_i == DCS_MODE_PP);
  wire       is_hm      = (mode_i == DCS_MODE_HM);
  wire       is_ip      = (mode_i == DCS_MODE_IP);
  wire       is_ipc     = is_ip || (mode_i == DCS_MODE_CSP);
  wire       halt       = cmd_q[`DCS_CMD_HALT];
  wire       start_rise = cmd_q[`DCS_CMD_START] && !start_prev_q;
  wire       flt_rise   = cmd_q[`DCS_CMD_FAULT_RESET] && !fault_rst_prev_q;
  wire [3:0] ctl        = cmd_q[3:0];
  wire       ctl_ok     = !cmd_q[`DCS_CMD_FAULT_RESET];
  // Transition commands decoded from bits 0 to 3 with bit 7 low.
  // state commands decoded
  wire       c_dis_volt = ctl_ok && !ctl[1];
  wire       c_qstop    = ctl_ok && ctl[1] && !ctl[2];
  wire       c_shutdown = ctl_ok && (ctl[2:0] == 3'h6);
  wire       c_sw_on    = ctl_ok && (ctl == 4'h7);
  wire       c_enable   = ctl_ok && (ctl == 4'hF);

  // ====================================================================
  // Drive state machine
  dcs_state_type st_q;
  dcs_state_type st_d;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      DCS_NOT_READY:  st_d = DCS_SW_ON_DIS;
      DCS_SW_ON_DIS: begin
        if (c_shutdown) begin
          st_d = DCS_READY;
        end
      end
      DCS_READY: begin
        if (c_dis_volt || c_qstop) begin
          st_d = DCS_SW_ON_DIS;
        end else if (c_enable || c_sw_on) begin
          st_d = DCS_SWITCHED;
        end
      end
      DCS_SWITCHED: begin
        if (c_dis_volt || c_qstop) begin
          st_d = DCS_SW_ON_DIS;
        end else if (c_shutdown) begin
          st_d = DCS_READY;
        end else if (c_enable) begin
          st_d = DCS_OP_ENABLED;
        end
      end
      DCS_OP_ENABLED: begin
        if (c_dis_volt) begin
          st_d = DCS_SW_ON_DIS;
        end else if (c_qstop) begin
          st_d = DCS_QSTOP;
        end else if (c_shutdown) begin
          st_d = DCS_READY;
        end else if (c_sw_on) begin
          st_d = DCS_SWITCHED;
        end
      end
      DCS_QSTOP: begin
        if (c_dis_volt || stop_done_i) begin
          st_d = DCS_SW_ON_DIS;
        end
      end
      DCS_FAULT_REAC: begin
        if (stop_done_i) begin
          st_d = DCS_FAULT;
        end
      end
      DCS_FAULT: begin
        if (flt_rise && !fault_i) begin
          st_d = DCS_SW_ON_DIS;
        end
      end
    endcase
    if (fault_i && (st_q != DCS_FAULT) && (st_q != DCS_FAULT_REAC)) begin
      st_d = DCS_FAULT_REAC;
    end
  end

  // Bits 6, 5, 3, 2, 1, 0; don't-care bit 5 is driven as 0.
  // state encoding
  logic [6:0] st_bits;
  assign st_bits = (st_q == DCS_SW_ON_DIS)  ? 7'h40 :
                   (st_q == DCS_READY)      ? 7'h21 :
                   (st_q == DCS_SWITCHED)   ? 7'h23 :
                   (st_q == DCS_OP_ENABLED) ? 7'h27 :
                   (st_q == DCS_QSTOP)      ? 7'h07 :
                   (st_q == DCS_FAULT_REAC) ? 7'h0F :
                   (st_q == DCS_FAULT)      ? 7'h08 : 7'h00;

  // ====================================================================
  // Interpolation speed check
  logic too_fast;

  dcs_ip_speed_check #(
    .POS_W(POS_W),
    .RAT_W(RAT_W),
    .PER_W(PER_W)
  ) u_speed (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .new_target_i(target_in_i),
    .demand_pos_i(demand_pos_i),
    .ratio_num_i (ratio_num_i),
    .ratio_den_i (ratio_den_i),
    .period_us_i (period_us_i),
    .too_fast_o  (too_fast)
  );

  // ====================================================================
  // Target handling
  // The check result lags the target by one cycle, so the target is held
  // for that cycle before it is accepted or dropped.
  logic [POS_W-1:0] tgt_buf_q;
  logic             tgt_chk_q;
  logic             pend_q;
  logic             ip_excess_q;

  wire go_now  = is_pp && start_rise && cmd_q[`DCS_CMD_IMMEDIATE];
  wire go_wait = is_pp && start_rise && !cmd_q[`DCS_CMD_IMMEDIATE];
  wire go_pend = pend_q && target_reached_i && !halt;
  wire take_pp = (go_now || go_pend) && !halt;
  wire [POS_W-1:0] pp_tgt = cmd_q[`DCS_CMD_RELATIVE] ? (target_pos_o + target_in_i)
                                                    : target_in_i;
  wire ip_drop = tgt_chk_q && is_ipc && too_fast;
  wire ip_take = tgt_chk_q && is_ipc && !too_fast;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      target_pos_o     <= '0;
      tgt_buf_q        <= '0;
      tgt_chk_q        <= 1'b0;
      pend_q           <= 1'b0;
      ip_excess_q      <= 1'b0;
      setpoint_start_o <= 1'b0;
      target_ignored_o <= 1'b0;
    end else if (ce_i) begin
      tgt_buf_q        <= target_in_i;
      tgt_chk_q        <= target_wr_i && is_ipc;
      setpoint_start_o <= take_pp || ip_take;
      target_ignored_o <= ip_drop;
      if (take_pp) begin
        target_pos_o <= pp_tgt;
      end else if (ip_take) begin
        target_pos_o <= tgt_buf_q;
      end
      // A deferred request in the cycle a pending one starts stays queued.
      if (go_wait) begin
        pend_q <= 1'b1;
      end else if (go_pend || !is_pp) begin
        pend_q <= 1'b0;
      end
      // Excess is held until a target passes the check again or the mode leaves IP and CSP.
      if (ip_drop) begin
        ip_excess_q <= 1'b1;
      end else if (ip_take || !is_ipc) begin
        ip_excess_q <= 1'b0;
      end
    end
  end

  // ====================================================================
  // Mode outputs and state word
  // halt every mode
  wire halt_d   = halt;
  wire home_d   = is_hm && cmd_q[`DCS_CMD_START] && !halt;
  wire interp_d = halt ? interp_en_o : (is_ip && cmd_q[`DCS_CMD_START]);

  logic [15:0] sw_d;
  always_comb begin
    sw_d                       = 16'h0000;
    sw_d[6:5]                  = st_bits[6:5];
    sw_d[3:0]                  = st_bits[3:0];
    sw_d[`DCS_ST_MAIN_POWER]   = main_power_i;
    sw_d[`DCS_ST_WARNING]      = warning_i;
    sw_d[`DCS_ST_ACTIVE_MODE]  = active_func_i;
    sw_d[`DCS_ST_REMOTE]       = (st_q != DCS_NOT_READY);
    sw_d[`DCS_ST_INT_LIMIT]    = sw_limit_clip_i || rot_q || fot_q || ip_excess_q;
    sw_d[`DCS_ST_TORQUE_LIMIT] = cmd_q[`DCS_CMD_TLIM_POS] || cmd_q[`DCS_CMD_TLIM_NEG];
    sw_d[`DCS_ST_SAFETY]       = safety_i;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q             <= DCS_NOT_READY;
      state_word_o     <= `DCS_STATE_WORD_RST;
      halt_o           <= 1'b0;
      homing_run_o     <= 1'b0;
      interp_en_o      <= 1'b0;
      power_stage_on_o <= 1'b0;
    end else if (ce_i) begin
      st_q             <= st_d;
      state_word_o     <= sw_d;
      halt_o           <= halt_d;
      homing_run_o     <= home_d;
      interp_en_o      <= interp_d;
      power_stage_on_o <= (st_q == DCS_OP_ENABLED) || (st_q == DCS_QSTOP);
    end
  end

endmodule
`default_nettype wire

// ==== dv/dcs_master_model.sv ====
// Fieldbus master model that writes the cyclic command word into the block.
// Assumes the bench asks for a write one cycle ahead on core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module dcs_master_model (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire dcs_pkg::dcs_mode_type mode_i,
  input  wire logic [15:0]           word_i,
  input  wire logic                  send_i,
  output logic [15:0]                cmd_word_o,
  output logic                       cmd_wr_o
);
  import dcs_pkg::*;
  // ======================================================================
  // Command word writer
  logic [15:0] keep_mask;

  assign keep_mask = (mode_i == DCS_MODE_PP) ? 16'hFFFF :
                     (mode_i inside {DCS_MODE_HM, DCS_MODE_IP}) ? 16'hFD9F : 16'hFD8F;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_word_o <= 16'h0000;
      cmd_wr_o   <= 1'b0;
    end else begin
      cmd_wr_o <= send_i;
      if (send_i) begin
        cmd_word_o <= word_i & keep_mask;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/dcs_drive_word_checker.sv ====
// Port checks for the drive command and state word block.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module dcs_drive_word_checker (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic        cmd_wr_i,
  input wire logic        main_power_i,
  input wire logic        warning_i,
  input wire logic        safety_i,
  input wire logic [15:0] state_word_o,
  input wire logic        halt_o,
  input wire logic        homing_run_o,
  input wire logic        interp_en_o,
  input wire logic        setpoint_start_o,
  input wire logic        target_ignored_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ======================================================================
  // Command write followed by a quiet spell long enough to settle
  sequence s_quiet;
    (ce_i && !cmd_wr_i)[*4];
  endsequence
  sequence s_tlim_on;
    ce_i && cmd_wr_i && (cmd_word_i[12:11] != 2'b00) ##1 s_quiet;
  endsequence
  sequence s_tlim_off;
    ce_i && cmd_wr_i && (cmd_word_i[12:11] == 2'b00) ##1 s_quiet;
  endsequence
  sequence s_halt_on;
    ce_i && cmd_wr_i && cmd_word_i[8] ##1 s_quiet;
  endsequence
  // ======================================================================
  // Assertions
  AST_RESET_WORD: assert property ($fell(rst_i) |-> state_word_o == 16'h0000)
    else $error("state word not zero after reset");
  AST_REMOTE: assert property ((state_word_o[6] || state_word_o[0]) |-> state_word_o[9])
    else $error("remote bit missing");
  AST_DISABLED_CODE: assert property (state_word_o[6] |-> state_word_o[3:0] == 4'h0)
    else $error("bad switch-on-disabled code");
  AST_READY_CODE: assert property (state_word_o[3:0] inside {4'h1, 4'h3} |->
    state_word_o[5] && !state_word_o[6])
    else $error("bad ready code");
  AST_POWER: assert property (main_power_i[*4] |-> state_word_o[4])
    else $error("power flag missing");
  AST_WARN: assert property (warning_i[*4] |-> state_word_o[7])
    else $error("warning flag missing");
  AST_SAFETY: assert property (safety_i[*4] |-> state_word_o[15])
    else $error("safety flag missing");
  AST_TLIM_SET: assert property (s_tlim_on |-> state_word_o[14])
    else $error("torque limit flag missing");
  AST_TLIM_CLR: assert property (s_tlim_off |-> !state_word_o[14])
    else $error("torque limit flag stuck");
  AST_HALT: assert property (s_halt_on |-> halt_o)
    else $error("halt not applied");
  AST_HOMING_GATE: assert property (homing_run_o |-> !halt_o)
    else $error("homing runs while halted");
  AST_INTERP_HOLD: assert property (halt_o |-> $stable(interp_en_o))
    else $error("interpolation changed while halted");
  AST_IGNORE: assert property (target_ignored_o |-> !setpoint_start_o ##[0:2] state_word_o[11])
    else $error("dropped target not flagged");
endmodule

bind dcs_drive_word dcs_drive_word_checker chk_u (
  .core_clk_i, .rst_i, .ce_i, .cmd_word_i, .cmd_wr_i, .main_power_i, .warning_i, .safety_i,
  .state_word_o, .halt_o, .homing_run_o, .interp_en_o, .setpoint_start_o, .target_ignored_o);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the drive command and state word block.
// Assumes the master model file and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dcs_pkg::*;
  typedef struct packed {
    logic [15:0] cmd;
    logic [5:0]  flg;
    logic [15:0] exp;
  } dcs_row_type;
  // ======================================================================
  // Signals
  logic core_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, send = 1'b0, cmd_wr_i;
  dcs_mode_type mode_i = DCS_MODE_PP;
  logic [15:0] word = 16'h0000, period_us_i = 16'h03E8, cmd_word_i, state_word_o;
  logic [31:0] target_in_i = 32'h0, demand_pos_i = 32'h0, ratio_num_i = 32'h1;
  logic [31:0] ratio_den_i = 32'h1, target_pos_o, n_start = 32'h0, n_ign = 32'h0;
  logic target_wr_i = 1'b0, target_reached_i = 1'b0, stop_done_i = 1'b0, fault_i = 1'b0;
  logic main_power_i = 1'b0, warning_i = 1'b0, active_func_i = 1'b0, safety_i = 1'b0;
  logic sw_limit_clip_i = 1'b0, reverse_overtravel_input = 1'b0;
  logic forward_overtravel_input = 1'b0;
  logic setpoint_start_o, target_ignored_o, halt_o, homing_run_o, interp_en_o, power_stage_on_o;
  int miscompares = 0;
  int compares = 0;
  dcs_row_type rows [12] = '{
    '{16'h0086, 6'h00, 16'h0240}, '{16'h0006, 6'h08, 16'h0231}, '{16'h0807, 6'h0C, 16'h42B3},
    '{16'h100F, 6'h0B, 16'hC337}, '{16'h000B, 6'h00, 16'h0207}, '{16'h0000, 6'h10, 16'h0240},
    '{16'h0006, 6'h00, 16'h0221}, '{16'h0007, 6'h08, 16'h0233}, '{16'h000F, 6'h08, 16'h0237},
    '{16'h000F, 6'h20, 16'h020F}, '{16'h000F, 6'h30, 16'h0208}, '{16'h0080, 6'h00, 16'h0240}};

  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    n_start <= n_start + 32'(setpoint_start_o);
    n_ign   <= n_ign + 32'(target_ignored_o);
  end

  dcs_master_model master_u (.core_clk_i, .rst_i, .mode_i, .word_i(word), .send_i(send),
    .cmd_word_o(cmd_word_i), .cmd_wr_o(cmd_wr_i));
  dcs_drive_word dut_u (.core_clk_i, .rst_i, .ce_i, .mode_i, .cmd_word_i, .cmd_wr_i,
    .target_in_i, .target_wr_i, .demand_pos_i, .ratio_num_i, .ratio_den_i, .period_us_i,
    .target_reached_i, .stop_done_i, .fault_i, .main_power_i, .warning_i, .active_func_i,
    .safety_i, .sw_limit_clip_i, .reverse_overtravel_input, .forward_overtravel_input,
    .state_word_o, .target_pos_o, .setpoint_start_o, .target_ignored_o, .halt_o,
    .homing_run_o, .interp_en_o, .power_stage_on_o);
  // ======================================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // One nanosecond past the edge keeps the compare clear of that edge's updates.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    #1;
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cmd(input logic [15:0] w);
    @(posedge core_clk_i);
    word <= w;
    send <= 1'b1;
    @(posedge core_clk_i);
    send <= 1'b0;
    tick(8);
  endtask
  task automatic put_target(input logic [31:0] t);
    @(posedge core_clk_i);
    target_in_i <= t;
    target_wr_i <= 1'b1;
    @(posedge core_clk_i);
    target_wr_i <= 1'b0;
    tick(6);
  endtask
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ======================================================================
  // Watchdog: a hang is counted as a mismatch.
  initial begin
    tick(20000);
    miscompares++;
    give_verdict();
  end
  // ======================================================================
  // Main sequence
  initial begin
    tick(2);
    rst_i <= 1'b0;
    tick(3);
    check("reset word", 32'(state_word_o), 32'h0240);
    check("power stage off", 32'(power_stage_on_o), 32'h0);
    foreach (rows[i]) begin
      {fault_i, stop_done_i, main_power_i, warning_i, active_func_i, safety_i} <= rows[i].flg;
      cmd(rows[i].cmd);
      check("state word", 32'(state_word_o), 32'(rows[i].exp));
    end
    cmd(16'h0006);
    cmd(16'h0007);
    cmd(16'h000F);
    check("power stage on", 32'(power_stage_on_o), 32'h1);
    target_in_i <= 32'h64;
    cmd(16'h003F);
    check("abs target", target_pos_o, 32'h64);
    target_in_i <= 32'h19;
    cmd(16'h000F);
    cmd(16'h007F);
    check("rel target", target_pos_o, 32'h7D);
    check("starts", n_start, 32'h2);
    target_in_i <= 32'h7;
    cmd(16'h000F);
    cmd(16'h001F);
    check("deferred held", target_pos_o, 32'h7D);
    target_reached_i <= 1'b1;
    tick(4);
    check("deferred run", target_pos_o, 32'h7);
    target_reached_i <= 1'b0;
    cmd(16'h010F);
    check("halt", 32'(halt_o), 32'h1);
    mode_i <= DCS_MODE_HM;
    cmd(16'h011F);
    check("homing halted", 32'(homing_run_o), 32'h0);
    cmd(16'h001F);
    check("homing run", 32'(homing_run_o), 32'h1);
    cmd(16'h000F);
    check("homing stop", 32'(homing_run_o), 32'h0);
    mode_i <= DCS_MODE_IP;
    cmd(16'h001F);
    check("interp on", 32'(interp_en_o), 32'h1);
    cmd(16'h010F);
    check("interp held", 32'(interp_en_o), 32'h1);
    cmd(16'h001F);
    put_target(32'h3FFFFF);
    check("fast ok", target_pos_o, 32'h3FFFFF);
    put_target(32'h400000);
    check("fast drop", target_pos_o, 32'h3FFFFF);
    check("ignored", n_ign, 32'h1);
    check("limit bit", 32'(state_word_o[11]), 32'h1);
    put_target(32'hA);
    check("limit clear", 32'(state_word_o[11]), 32'h0);
    for (int k = 0; k < 3; k++) begin
      {sw_limit_clip_i, reverse_overtravel_input, forward_overtravel_input} <= 3'h1 << k;
      tick(10);
      check("limit source", 32'(state_word_o[11]), 32'h1);
      {sw_limit_clip_i, reverse_overtravel_input, forward_overtravel_input} <= 3'h0;
      tick(10);
      check("limit idle", 32'(state_word_o[11]), 32'h0);
    end
    // A shutdown sent while the clock enable is low must leave the state alone.
    ce_i <= 1'b0;
    cmd(16'h0006);
    check("frozen word", 32'(state_word_o), 32'h0227);
    ce_i <= 1'b1;
    rst_i <= 1'b1;
    tick(2);
    check("word in reset", 32'(state_word_o), 32'h0);
    rst_i <= 1'b0;
    tick(3);
    check("word after reset", 32'(state_word_o), 32'h0240);
    give_verdict();
  end
endmodule
`default_nettype wire
